// File: verilog/spimsp_port.sv
// Serial port that runs as master or slave, 3-wire or 4-wire
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - Shift one bit out and one bit in on every serial clock cycle.
// - Runs as master or slave, in 3-wire or 4-wire form.
// - Slave with select input answers only while select is held low.
// - Multi-master: in 4-wire input form, low select from another master drops master mode.
// - Master may drive the select line as a chip select output.
// - 3-wire form ignores the select line entirely.
// - Rate setting shapes the serial clock only in master mode.
// - Serial clock equals system clock over two times the sum of rate and one.
// - Rate register is 8-bit read/write at 0xA2, resetting to zero.
module spimsp_port
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe_b,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe_b,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe_b,
  input  wire logic       slave_select_n_in,
  output logic            slave_select_n_out,
  output logic            slave_select_n_oe_b
);
  import spimsp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers, bits ordered select, miso, mosi, sck
  logic [3:0] pin_in, sy1_q, sy2_q, sy3_q, flt_q, flt_d;
  logic       sck_f_q, mosi_f_q, miso_f_q, ss_f_q;

  assign pin_in = {slave_select_n_in, miso_in, mosi_in, sck_in};
  assign {ss_f_q, miso_f_q, mosi_f_q, sck_f_q} = flt_q;

  always_comb
  begin
    // Change counts once stages two and three agree
    flt_d = (sy3_q & sy2_q) | (flt_q & (sy3_q ^ sy2_q));
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Select idles high, so it resets high to avoid a false select
      sy1_q <= 4'h8;
      sy2_q <= 4'h8;
      sy3_q <= 4'h8;
      flt_q <= 4'h8;
    end
    else
    begin
      sy1_q <= pin_in;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      flt_q <= flt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers and shifter
  logic [7:0] rate_q, rate_d, ctrl_q, ctrl_d, shift_q, shift_d, rx_q, rx_d;
  logic [7:0] div_q, div_d, rdata_q, rdata_d;
  logic [3:0] bits_q, bits_d;
  logic       busy_q, busy_d, done_q, done_d, modef_q, modef_d;
  logic       sck_q, sck_d, sck_prev_q, sck_prev_d, ss_q, ss_d;
  logic       master, sel_active, s_rise, s_fall;
  spimsp_wire_t wire_mode;

  assign master    = ctrl_q[CTRL_MASTER];
  assign wire_mode = spimsp_wire_t'(ctrl_q[CTRL_MODE_LO +: 2]);
  assign sel_active = (wire_mode == SPIMSP_WIRE3) ? 1'b1 : !ss_f_q;
  assign s_rise     = sck_f_q && !sck_prev_q;
  assign s_fall     = !sck_f_q && sck_prev_q;

  always_comb
  begin
    rate_d     = rate_q;
    ctrl_d     = ctrl_q;
    shift_d    = shift_q;
    rx_d       = rx_q;
    div_d      = div_q;
    bits_d     = bits_q;
    busy_d     = busy_q;
    done_d     = done_q;
    modef_d    = modef_q;
    sck_d      = sck_q;
    ss_d       = ss_q;
    sck_prev_d = sck_f_q;
    rdata_d    = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_RATE: rdata_d = rate_q;
        ADDR_DATA: rdata_d = rx_q;
        ADDR_CTRL: rdata_d = ctrl_q;
        ADDR_STAT: rdata_d = {5'h00, modef_q, done_q, busy_q};
        default:   rdata_d = 8'h00;
      endcase
      // Reading status clears done and fault
      if (reg_addr == ADDR_STAT)
      begin
        done_d  = 1'b0;
        modef_d = 1'b0;
      end
    end
    if (reg_wr)
    begin
      if (reg_addr == ADDR_RATE)
        rate_d = reg_wdata;
      if (reg_addr == ADDR_CTRL)
        ctrl_d = reg_wdata;
      if (reg_addr == ADDR_DATA && !busy_q)
      begin
        shift_d = reg_wdata;
        if (master)
        begin
          busy_d = 1'b1;
          bits_d = 4'h0;
          div_d  = 8'h00;
          sck_d  = 1'b0;
          ss_d   = 1'b0;
        end
      end
    end
    if (master)
    begin
      if (wire_mode == SPIMSP_WIRE4_IN && !ss_f_q)
      begin
        ctrl_d[CTRL_MASTER] = 1'b0;
        modef_d = 1'b1;
        busy_d  = 1'b0;
        sck_d   = 1'b0;
        ss_d    = 1'b1;
      end
      else if (busy_q)
      begin
        if (div_q == rate_q)
        begin
          div_d = 8'h00;
          sck_d = !sck_q;
          if (!sck_q)
            rx_d = {rx_q[6:0], miso_f_q};
          else
          begin
            shift_d = {shift_q[6:0], 1'b0};
            bits_d  = bits_q + 4'h1;
            if (bits_q == BITS_PER_BYTE - 4'h1)
            begin
              busy_d = 1'b0;
              done_d = 1'b1;
              ss_d   = 1'b1;
            end
          end
        end
        else
          div_d = div_q + 8'h01;
      end
    end
    else if (sel_active)
    begin
      if (s_rise)
      begin
        rx_d   = {rx_q[6:0], mosi_f_q};
        busy_d = 1'b1;
      end
      if (s_fall)
      begin
        shift_d = {shift_q[6:0], 1'b0};
        bits_d  = bits_q + 4'h1;
        if (bits_q == BITS_PER_BYTE - 4'h1)
        begin
          bits_d = 4'h0;
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end
    end
    else
    begin
      bits_d = 4'h0;
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rate_q     <= RATE_RESET;
      ctrl_q     <= CTRL_RESET;
      shift_q    <= 8'h00;
      rx_q       <= 8'h00;
      div_q      <= 8'h00;
      bits_q     <= 4'h0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      modef_q    <= 1'b0;
      sck_q      <= 1'b0;
      ss_q       <= 1'b1;
      sck_prev_q <= 1'b0;
      rdata_q    <= 8'h00;
    end
    else
    begin
      rate_q     <= rate_d;
      ctrl_q     <= ctrl_d;
      shift_q    <= shift_d;
      rx_q       <= rx_d;
      div_q      <= div_d;
      bits_q     <= bits_d;
      busy_q     <= busy_d;
      done_q     <= done_d;
      modef_q    <= modef_d;
      sck_q      <= sck_d;
      ss_q       <= ss_d;
      sck_prev_q <= sck_prev_d;
      rdata_q    <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drive, enables low while driving
  assign reg_rdata           = rdata_q;
  assign sck_out             = sck_q;
  assign sck_oe_b            = !master;
  assign mosi_out            = shift_q[7];
  assign mosi_oe_b           = !master;
  assign miso_out            = shift_q[7];
  // Slave releases MISO when not selected, letting other slaves share it
  assign miso_oe_b           = master || !sel_active;
  assign slave_select_n_out  = ss_q;
  assign slave_select_n_oe_b = !(master && wire_mode == SPIMSP_WIRE4_OUT);

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_master_write;
    reg_wr && reg_addr == ADDR_DATA && master && !busy_q && wire_mode != SPIMSP_WIRE4_IN;
  endsequence

  a_rate_reg_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == ADDR_RATE |=> rate_q == $past(reg_wdata))
    else $error("rate register did not take write");
  a_rate_readback: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == ADDR_RATE && !(reg_wr) |=> reg_rdata == $past(rate_q))
    else $error("rate readback wrong");
  a_xfer_starts: assert property (@(posedge clk) disable iff (!rst_b)
    s_master_write |=> busy_q)
    else $error("master write did not start transfer");
  a_sck_halfper: assert property (@(posedge clk) disable iff (!rst_b)
    master && busy_q && $changed(sck_q) && rate_q == 8'h00 && $stable(rate_q)
    |=> !busy_q || $changed(sck_q))
    else $error("serial clock half period wrong");
  a_slave_no_sck: assert property (@(posedge clk) disable iff (!rst_b)
    !master |-> sck_oe_b)
    else $error("slave drives serial clock");
  a_modef_drop: assert property (@(posedge clk) disable iff (!rst_b)
    master && wire_mode == SPIMSP_WIRE4_IN && !ss_f_q |=> !master && modef_q)
    else $error("mode fault did not drop master");
  a_ss_output: assert property (@(posedge clk) disable iff (!rst_b)
    busy_q && master |-> slave_select_n_oe_b || !slave_select_n_out)
    else $error("chip select not low during transfer");
  a_slave_gated: assert property (@(posedge clk) disable iff (!rst_b)
    !master && !sel_active |=> !busy_q && bits_q == 4'h0)
    else $error("unselected slave took bits");
  a_wire3_sel: assert property (@(posedge clk) disable iff (!rst_b)
    wire_mode == SPIMSP_WIRE3 |-> sel_active)
    else $error("3-wire form looked at select");
  a_full_duplex: assert property (@(posedge clk) disable iff (!rst_b)
    master && busy_q && $rose(sck_q) |-> rx_q[0] == $past(miso_f_q))
    else $error("receive bit not sampled on rise");
endmodule

// File: verilog/spimsp_pkg.sv
// Package of register offsets, reset values and mode codes for the serial port
package spimsp_pkg;
  localparam logic [7:0] ADDR_RATE     = 8'hA2;
  localparam logic [7:0] ADDR_DATA     = 8'hA3;
  localparam logic [7:0] ADDR_CTRL     = 8'hA1;
  localparam logic [7:0] ADDR_STAT     = 8'hA0;
  localparam logic [7:0] RATE_RESET    = 8'h00;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam int         CTRL_MASTER   = 0;
  localparam int         CTRL_MODE_LO  = 1;
  localparam int         CTRL_SS_OUT   = 3;
  localparam int         STAT_BUSY     = 0;
  localparam int         STAT_DONE     = 1;
  localparam int         STAT_MODEF    = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int         SYNC_STAGES   = 3;
  typedef enum logic [1:0]
  {
    SPIMSP_WIRE3    = 2'b00,
    SPIMSP_WIRE4_IN = 2'b01,
    SPIMSP_WIRE4_OUT = 2'b10
  } spimsp_wire_t;
endpackage

// File: testbench/spimsp_partner.sv
// Behavioural slave on the far side of a master-mode transfer
`timescale 1ns/1ps
module spimsp_partner
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh_q = 8'h00;
  initial rx_byte = 8'h00;
  always @(negedge sel_n) sh_q = tx_byte;
  always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck) if (!sel_n) sh_q = {sh_q[6:0], 1'b0};
  // Released line shows the inverse, so a stale bit never matches by luck
  assign miso = sel_n ? ~sh_q[7] : sh_q[7];
endmodule

// File: testbench/spimsp_port_tb.sv
// Self-checking bench for the master/slave serial port
`timescale 1ns/1ps
module spimsp_port_tb;
  import spimsp_pkg::*;
  logic       clk, rst_b, reg_wr, reg_rd, m_sck, m_mosi, ss_drv, gp_sel_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ptx, prx, d, s, tx;
  logic       sck_out, sck_oe_b, mosi_out, mosi_oe_b, miso_out, miso_oe_b;
  logic       slave_select_n_out, slave_select_n_oe_b;
  logic [7:0] exp_q[$];
  wire        sck_w = sck_oe_b ? m_sck : sck_out;
  wire        mosi_w = mosi_oe_b ? m_mosi : mosi_out;
  wire        ss_w = slave_select_n_oe_b ? ss_drv : slave_select_n_out;
  wire        p_sel_n = slave_select_n_oe_b ? gp_sel_n : slave_select_n_out;
  wire        p_miso;
  int         fail_count = 0, check_count = 0, cyc = 0;
  spimsp_port dut
  (
    .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sck_in(sck_w),
    .sck_out, .sck_oe_b, .mosi_in(mosi_w), .mosi_out, .mosi_oe_b, .miso_in(p_miso),
    .miso_out, .miso_oe_b, .slave_select_n_in(ss_w), .slave_select_n_out,
    .slave_select_n_oe_b
  );
  spimsp_partner far
  (
    .sck(sck_w), .mosi(mosi_w), .sel_n(p_sel_n), .tx_byte(ptx), .miso(p_miso), .rx_byte(prx)
  );
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // Gap after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask
  task automatic xfer(input logic [1:0] mode, input logic [7:0] rate);
    int n;
    tx = 8'($urandom);
    ptx = 8'($urandom);
    exp_q.push_back(ptx);
    ss_drv <= 1'b1;
    wr(ADDR_CTRL, {5'h00, mode, 1'b1});
    wr(ADDR_RATE, rate);
    gp_sel_n = (mode == 2'h2);
    wr(ADDR_DATA, tx);
    n = 0;
    while (sck_out !== 1'b1 && n < 600) @(posedge clk) #1 n++;
    chk(8'(slave_select_n_oe_b), 8'(mode != 2'h2), "select drive");
    chk(8'({sck_oe_b, mosi_oe_b}), 8'h00, "master drive");
    n = 0;
    while (sck_out === 1'b1 && n < 600) @(posedge clk) #1 n++;
    chk(8'(n), rate + 8'h01, "sck high half");
    n = 0;
    while (sck_out === 1'b0 && n < 600) @(posedge clk) #1 n++;
    chk(8'(n), rate + 8'h01, "sck low half");
    n = 0;
    d = 8'h00;
    while (d[STAT_DONE] !== 1'b1 && n < 400)
    begin
      rd(ADDR_STAT, d);
      n++;
    end
    chk(8'(n < 400), 8'h01, "done timeout");
    gp_sel_n = 1'b1;
    chk(8'(slave_select_n_out), 8'h01, "select released");
    chk(prx, tx, "byte sent");
    rd(ADDR_DATA, d);
    s = exp_q.pop_front();
    if (rate > 8'h03) chk(d, s, "byte received");
    $display("test master mode %0d rate %0d done", mode, rate);
  endtask
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hCDCE512C));
    rst_b = 1'b0;
    {reg_wr, reg_rd, m_sck, m_mosi} = 4'h0;
    {ss_drv, gp_sel_n} = 2'h3;
    {reg_addr, reg_wdata, ptx} = 24'h000000;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_RATE, d);
    chk(d, RATE_RESET, "rate reset");
    rd(8'h5A, d);
    chk(d, 8'h00, "unmapped read");
    s = 8'($urandom);
    wr(ADDR_RATE, s);
    rd(ADDR_RATE, d);
    chk(d, s, "rate readback");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_RATE, d);
    chk(d, RATE_RESET, "rate after reset");
    $display("test registers done");
    for (int m = 0; m < 3; m++)
    begin
      xfer(2'(m), 8'h00);
      xfer(2'(m), 8'h04 + 8'($urandom_range(3)));
    end
    ss_drv <= 1'b0;
    wr(ADDR_CTRL, 8'h03);
    wr(ADDR_DATA, 8'hA5);
    repeat (8) @(posedge clk);
    #1 chk(8'(sck_oe_b), 8'h01, "master dropped");
    rd(ADDR_STAT, d);
    chk(8'(d[STAT_MODEF]), 8'h01, "mode fault");
    $display("test contention done");
    ss_drv <= 1'b1;
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_RATE, 8'($urandom));
    tx = 8'($urandom);
    ptx = 8'($urandom);
    wr(ADDR_DATA, tx);
    ss_drv <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 7; i >= 0; i--)
    begin
      m_mosi <= ptx[i];
      repeat (6) @(posedge clk);
      s[i] = miso_out;
      m_sck <= 1'b1;
      repeat (6) @(posedge clk);
      m_sck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    #1 chk(8'({sck_oe_b, mosi_oe_b, miso_oe_b}), 8'h06, "slave drive");
    chk(s, tx, "slave sent");
    rd(ADDR_DATA, d);
    chk(d, ptx, "slave received");
    ss_drv <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(8'(miso_oe_b), 8'h01, "slave released");
    $display("test slave done");
    close_out();
  end
endmodule
